//--- rtl/fsp_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fsp_fifo_if #(parameter int AW = 3, parameter int DW = 8);
	logic we;
	logic [AW-1:0] waddr;
	logic [AW-1:0] raddr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- rtl/fsp_fifo_mem.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_fifo_mem #(parameter int AW = 3, parameter int DW = 8) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Storage port
	fsp_fifo_if.mem port
);
	logic [DW-1:0] store [0:(1<<AW)-1];

	always_ff @(posedge clock) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// Registered read keeps the bus read path short
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port.rdata <= '0;
		end else begin
			port.rdata <= store[port.raddr];
		end
	end
endmodule
`default_nettype wire

//--- rtl/fsp_params.svh
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
// Register offsets
`define FSP_ADDR_CTRL 16'hc070
`define FSP_ADDR_BAUD 16'hc072
`define FSP_ADDR_GAP 16'hc074
`define FSP_ADDR_TXDATA 16'hc076
`define FSP_ADDR_RXDATA 16'hc078
`define FSP_ADDR_STATUS 16'hc07a
`define FSP_ADDR_MASK 16'hc07c
`define FSP_ADDR_BLKADDR 16'hc07e
// Control fields
`define FSP_CTRL_BLK_RX 0
`define FSP_CTRL_BLK_TX 1
`define FSP_CTRL_HS 2
// Event bits of status and mask
`define FSP_EV_RX 0
`define FSP_EV_TX 1
`define FSP_EV_OVR 2
`define FSP_EV_FRM 3
// Live status bits
`define FSP_STAT_READY 8
`define FSP_STAT_BUSY 9
// Reset values and the block gap bias
`define FSP_BAUD_RST 16'h0017
`define FSP_GAP_RST 16'h000b
`define FSP_GAP_BIAS 16'h0009
// Timing
`define FSP_CLK_PS 10000
`define FSP_CTS_SETUP_PS 31250
`define FSP_CTS_SETUP_CYC ((`FSP_CTS_SETUP_PS + `FSP_CLK_PS - 1) / `FSP_CLK_PS)
`endif

//--- rtl/fsp_pkg.sv
`default_nettype none
package fsp_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_RTS, TX_START, TX_DATA, TX_STOP} fsp_tx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fsp_rx_t;
endpackage
`default_nettype wire

//--- rtl/fsp_serial_port.sv
// Summary of operation
// - Bytes go out and come in LSB first; high line means one.
// - One bit time is the programmed baud divisor period; all framing uses it.
// - Block transmit frames match byte frames except for the stop length.
// - Block transmit stop lasts gap register minus nine bit times, or one bit time when gap is below ten.
// - Receive line is synchronised before any sampling.
// - Mid-bit sampling tolerates five percent rate error at divisor 23 or more.
// - Byte mode receive fills a FIFO; ready while it is not empty.
// - Block mode receive writes each byte straight to memory.
// - With handshake, start bit waits while clear-to-send is low.
// - Request-to-send drops during the third data bit.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_params.svh"
module fsp_serial_port #(parameter int FIFO_AW = 3) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Serial link
	input wire logic serial_receive_line,
	output logic serial_transmit_line,
	input wire logic clear_to_send_input,
	output logic request_to_send_output,
	// Block mode memory writes
	output logic mem_write,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	// Status
	output logic receive_ready_flag,
	output logic irq
);
	import fsp_pkg::*;

	function automatic logic fsp_hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction

	logic [2:0] ctrl, next_ctrl;
	logic [15:0] baud, next_baud, gap, next_gap, blk_addr, next_blk_addr;
	logic [3:0] status, next_status, mask, next_mask;
	logic [15:0] rd_q, next_rd_q;
	logic rd_rx, next_rd_rx;
	logic next_mem_write;
	logic [15:0] next_mem_addr;
	logic [7:0] next_mem_wdata;
	logic [FIFO_AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic fifo_empty, fifo_full, push, pop, load, blk_rx;
	fsp_tx_t tx_state, next_tx_state;
	logic [15:0] tx_cnt, next_tx_cnt, stop_left, next_stop_left;
	logic [7:0] tx_shift, next_tx_shift, tx_hold, next_tx_hold;
	logic [2:0] tx_idx, next_tx_idx;
	logic [3:0] rts_cnt, next_rts_cnt;
	logic rts, next_rts, txd, next_txd, tx_done;
	logic rx_s1, rx_s2;
	fsp_rx_t rx_state, next_rx_state;
	logic [15:0] rx_cnt, next_rx_cnt;
	logic [7:0] rx_shift, next_rx_shift;
	logic [2:0] rx_idx, next_rx_idx;
	logic rx_done, rx_ferr;

	fsp_fifo_if #(.AW(FIFO_AW), .DW(8)) fifo();

	fsp_fifo_mem #(.AW(FIFO_AW), .DW(8)) u_mem (
		.clock(clock),
		.rstn(rstn),
		.port(fifo.mem)
	);

	assign blk_rx = ctrl[`FSP_CTRL_BLK_RX];
	assign fifo_empty = wr_ptr == rd_ptr;
	assign fifo_full = (wr_ptr[FIFO_AW] != rd_ptr[FIFO_AW]) &&
		(wr_ptr[FIFO_AW-1:0] == rd_ptr[FIFO_AW-1:0]);
	assign push = rx_done && !blk_rx && !fifo_full;
	assign pop = reg_read && fsp_hit(reg_addr, `FSP_ADDR_RXDATA) && !fifo_empty;
	assign load = reg_write && fsp_hit(reg_addr, `FSP_ADDR_TXDATA) && tx_state == TX_IDLE;
	assign fifo.we = push;
	assign fifo.waddr = wr_ptr[FIFO_AW-1:0];
	assign fifo.wdata = rx_shift;
	assign fifo.raddr = rd_ptr[FIFO_AW-1:0];
	assign receive_ready_flag = !fifo_empty;
	assign reg_rdata = rd_rx ? {8'h00, fifo.rdata} : rd_q;
	assign irq = |(status & mask);
	assign serial_transmit_line = txd;
	assign request_to_send_output = rts;

	// Register file, memory writes and FIFO pointers
	always_comb begin
		next_ctrl = ctrl;
		next_baud = baud;
		next_gap = gap;
		next_mask = mask;
		next_blk_addr = blk_addr;
		next_status = status;
		next_rd_q = 16'h0000;
		next_rd_rx = 1'b0;
		next_mem_write = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_wr_ptr = wr_ptr + {{FIFO_AW{1'b0}}, push};
		next_rd_ptr = rd_ptr + {{FIFO_AW{1'b0}}, pop};
		if (reg_write) begin
			if (fsp_hit(reg_addr, `FSP_ADDR_CTRL)) next_ctrl = reg_wdata[2:0];
			if (fsp_hit(reg_addr, `FSP_ADDR_BAUD)) next_baud = reg_wdata;
			if (fsp_hit(reg_addr, `FSP_ADDR_GAP)) next_gap = reg_wdata;
			if (fsp_hit(reg_addr, `FSP_ADDR_MASK)) next_mask = reg_wdata[3:0];
			if (fsp_hit(reg_addr, `FSP_ADDR_BLKADDR)) next_blk_addr = reg_wdata;
			if (fsp_hit(reg_addr, `FSP_ADDR_STATUS)) next_status = status & ~reg_wdata[3:0];
		end
		if (rx_done && blk_rx) begin
			next_mem_write = 1'b1;
			next_mem_addr = blk_addr;
			next_mem_wdata = rx_shift;
			next_blk_addr = blk_addr + 16'h0001;
		end
		// Set after clear so a same-cycle event survives the write
		next_status[`FSP_EV_RX] = next_status[`FSP_EV_RX] | rx_done;
		next_status[`FSP_EV_TX] = next_status[`FSP_EV_TX] | tx_done;
		next_status[`FSP_EV_OVR] = next_status[`FSP_EV_OVR] | (rx_done && !blk_rx && fifo_full);
		next_status[`FSP_EV_FRM] = next_status[`FSP_EV_FRM] | rx_ferr;
		if (reg_read) begin
			if (fsp_hit(reg_addr, `FSP_ADDR_CTRL)) next_rd_q = {13'h0000, ctrl};
			if (fsp_hit(reg_addr, `FSP_ADDR_BAUD)) next_rd_q = baud;
			if (fsp_hit(reg_addr, `FSP_ADDR_GAP)) next_rd_q = gap;
			if (fsp_hit(reg_addr, `FSP_ADDR_MASK)) next_rd_q = {12'h000, mask};
			if (fsp_hit(reg_addr, `FSP_ADDR_BLKADDR)) next_rd_q = blk_addr;
			if (fsp_hit(reg_addr, `FSP_ADDR_RXDATA)) next_rd_rx = !fifo_empty;
			if (fsp_hit(reg_addr, `FSP_ADDR_STATUS)) begin
				next_rd_q = {12'h000, status};
				next_rd_q[`FSP_STAT_READY] = !fifo_empty;
				next_rd_q[`FSP_STAT_BUSY] = tx_state != TX_IDLE;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl <= 3'h0;
			baud <= `FSP_BAUD_RST;
			gap <= `FSP_GAP_RST;
			mask <= 4'h0;
			blk_addr <= 16'h0000;
			status <= 4'h0;
			rd_q <= 16'h0000;
			rd_rx <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			ctrl <= next_ctrl;
			baud <= next_baud;
			gap <= next_gap;
			mask <= next_mask;
			blk_addr <= next_blk_addr;
			status <= next_status;
			rd_q <= next_rd_q;
			rd_rx <= next_rd_rx;
			mem_write <= next_mem_write;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	// Transmitter; a bit lasts baud+1 clocks
	always_comb begin
		next_tx_state = tx_state;
		next_tx_cnt = tx_cnt;
		next_tx_shift = tx_shift;
		next_tx_hold = tx_hold;
		next_tx_idx = tx_idx;
		next_stop_left = stop_left;
		next_rts_cnt = rts_cnt;
		next_rts = rts;
		tx_done = 1'b0;
		case (tx_state)
			TX_IDLE: begin
				if (load) begin
					next_tx_shift = reg_wdata[7:0];
					next_tx_hold = reg_wdata[7:0];
					next_tx_cnt = baud;
					if (ctrl[`FSP_CTRL_HS]) begin
						next_tx_state = TX_RTS;
						next_rts = 1'b1;
						next_rts_cnt = 4'h0;
					end else begin
						next_tx_state = TX_START;
					end
				end
			end
			TX_RTS: begin
				// Clear-to-send is only trusted once the partner's setup time has passed
				if (rts_cnt < 4'(`FSP_CTS_SETUP_CYC)) begin
					next_rts_cnt = rts_cnt + 4'h1;
				end else if (clear_to_send_input) begin
					next_tx_state = TX_START;
				end
			end
			TX_START: begin
				if (tx_cnt == 16'h0000) begin
					next_tx_state = TX_DATA;
					next_tx_idx = 3'h0;
					next_tx_cnt = baud;
				end else begin
					next_tx_cnt = tx_cnt - 16'h0001;
				end
			end
			TX_DATA: begin
				if (tx_cnt == 16'h0000) begin
					next_tx_cnt = baud;
					next_tx_shift = {1'b0, tx_shift[7:1]};
					next_tx_idx = tx_idx + 3'h1;
					if (tx_idx == 3'h1) next_rts = 1'b0;
					if (tx_idx == 3'h7) begin
						next_tx_state = TX_STOP;
						next_stop_left = 16'h0001;
						if (ctrl[`FSP_CTRL_BLK_TX] && gap > (`FSP_GAP_BIAS + 16'h0001)) begin
							next_stop_left = gap - `FSP_GAP_BIAS;
						end
					end
				end else begin
					next_tx_cnt = tx_cnt - 16'h0001;
				end
			end
			TX_STOP: begin
				if (tx_cnt != 16'h0000) begin
					next_tx_cnt = tx_cnt - 16'h0001;
				end else if (stop_left <= 16'h0001) begin
					next_tx_state = TX_IDLE;
					tx_done = 1'b1;
				end else begin
					next_stop_left = stop_left - 16'h0001;
					next_tx_cnt = baud;
				end
			end
			default: next_tx_state = TX_IDLE;
		endcase
		next_txd = 1'b1;
		if (next_tx_state == TX_START) next_txd = 1'b0;
		if (next_tx_state == TX_DATA) next_txd = next_tx_shift[0];
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_state <= TX_IDLE;
			tx_cnt <= 16'h0000;
			tx_shift <= 8'h00;
			tx_hold <= 8'h00;
			tx_idx <= 3'h0;
			stop_left <= 16'h0000;
			rts_cnt <= 4'h0;
			rts <= 1'b0;
			txd <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_cnt <= next_tx_cnt;
			tx_shift <= next_tx_shift;
			tx_hold <= next_tx_hold;
			tx_idx <= next_tx_idx;
			stop_left <= next_stop_left;
			rts_cnt <= next_rts_cnt;
			rts <= next_rts;
			txd <= next_txd;
		end
	end

	// Receiver: sampling at mid-bit from the start edge leaves half a bit of
	// margin over ten bits, which covers a five percent rate error
	always_comb begin
		next_rx_state = rx_state;
		next_rx_cnt = rx_cnt;
		next_rx_shift = rx_shift;
		next_rx_idx = rx_idx;
		rx_done = 1'b0;
		rx_ferr = 1'b0;
		case (rx_state)
			RX_IDLE: begin
				if (!rx_s2) begin
					next_rx_state = RX_START;
					next_rx_cnt = {1'b0, baud[15:1]};
				end
			end
			RX_START: begin
				if (rx_cnt != 16'h0000) begin
					next_rx_cnt = rx_cnt - 16'h0001;
				end else if (!rx_s2) begin
					next_rx_state = RX_DATA;
					next_rx_idx = 3'h0;
					next_rx_cnt = baud;
				end else begin
					next_rx_state = RX_IDLE;
				end
			end
			RX_DATA: begin
				if (rx_cnt != 16'h0000) begin
					next_rx_cnt = rx_cnt - 16'h0001;
				end else begin
					next_rx_shift = {rx_s2, rx_shift[7:1]};
					next_rx_idx = rx_idx + 3'h1;
					next_rx_cnt = baud;
					if (rx_idx == 3'h7) next_rx_state = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_cnt != 16'h0000) begin
					next_rx_cnt = rx_cnt - 16'h0001;
				end else begin
					next_rx_state = RX_IDLE;
					rx_done = rx_s2;
					rx_ferr = !rx_s2;
				end
			end
			default: next_rx_state = RX_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_state <= RX_IDLE;
			rx_cnt <= 16'h0000;
			rx_shift <= 8'h00;
			rx_idx <= 3'h0;
		end else begin
			rx_s1 <= serial_receive_line;
			rx_s2 <= rx_s1;
			rx_state <= next_rx_state;
			rx_cnt <= next_rx_cnt;
			rx_shift <= next_rx_shift;
			rx_idx <= next_rx_idx;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence fsp_start_enter;
		tx_state != TX_START ##1 tx_state == TX_START;
	endsequence
	sequence fsp_stop_enter;
		tx_state == TX_DATA ##1 tx_state == TX_STOP;
	endsequence

	AST_LSB_FIRST: assert property (tx_state == TX_DATA && tx_idx == 3'h0 |-> txd == tx_hold[0])
		else $error("First data bit is not the byte LSB");
	AST_START_HOLD: assert property (tx_state == TX_START && tx_cnt != 16'h0000 |=> tx_state == TX_START && !txd)
		else $error("Start bit ended before its bit time");
	AST_START_LOW: assert property (fsp_start_enter |-> !txd)
		else $error("Start bit not low");
	AST_GAP_LEN: assert property (fsp_stop_enter ##0 (ctrl[`FSP_CTRL_BLK_TX] && gap > 16'h000a)
		|-> stop_left == gap - 16'h0009)
		else $error("Block stop length differs from gap minus nine");
	AST_BYTE_STOP: assert property (fsp_stop_enter ##0 !ctrl[`FSP_CTRL_BLK_TX] |-> stop_left == 16'h0001 && txd)
		else $error("Byte stop not one high bit");
	AST_CTS_HOLD: assert property (tx_state == TX_RTS && !clear_to_send_input |=> tx_state == TX_RTS)
		else $error("Transmission started while clear-to-send low");
	AST_RTS_SETUP: assert property (fsp_start_enter ##0 ctrl[`FSP_CTRL_HS] |-> $past(rts, 4))
		else $error("Start bit too soon after request-to-send");
	AST_RTS_DROP: assert property (tx_state == TX_DATA && tx_idx == 3'h2 |-> !rts)
		else $error("Request-to-send still high in third data bit");
	AST_RTS_KEEP: assert property (tx_state == TX_DATA && tx_idx < 3'h2
		&& $past(rts) |-> rts)
		else $error("Request-to-send dropped too early");
	AST_READY: assert property (push |=> receive_ready_flag)
		else $error("Ready flag low with a byte queued");
	AST_BLOCK_WR: assert property (rx_done && blk_rx |=> mem_write && mem_wdata == $past(rx_shift) && !$past(push))
		else $error("Block byte not written to memory");
	AST_SYNC: assert property (rx_state == RX_IDLE && rx_s2 |=> rx_state == RX_IDLE)
		else $error("Receiver left idle on a high line");
endmodule
`default_nettype wire

//--- verif/fast_async_serial_port_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "fsp_params.svh"
module fast_async_serial_port_test;
	typedef struct {logic [15:0] addr; logic [15:0] value;} fsp_reg_row_t;
	typedef struct {logic [15:0] ctrl; logic [15:0] gap; logic [7:0] data; int cycles;} fsp_tx_row_t;
	typedef struct {logic [7:0] data; int len;} fsp_rx_row_t;
	logic clock;
	logic rstn;
	logic reg_write;
	logic reg_read;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata;
	logic mem_write;
	logic rxd;
	logic txd;
	logic cts;
	logic rts;
	logic ready;
	logic irq;
	logic [15:0] rd_val;
	logic [23:0] mem_seen[$];
	int n_fail = 0;
	int comparisons = 0;
	int n;
	fsp_reg_row_t reg_rows[7] = '{
		'{`FSP_ADDR_CTRL, 16'h0000}, '{`FSP_ADDR_BAUD, 16'h0017}, '{`FSP_ADDR_GAP, 16'h000b},
		'{`FSP_ADDR_STATUS, 16'h0000}, '{`FSP_ADDR_MASK, 16'h0000},
		'{`FSP_ADDR_BLKADDR, 16'h0000}, '{16'hc080, 16'h0000}};
	// Load edge to done: start and eight data bits, then the stop, 24 clocks a bit;
	// the handshake row adds the four-cycle request setup plus the clear-to-send sample
	fsp_tx_row_t tx_rows[5] = '{
		'{16'h0000, 16'h000b, 8'h35, 216 + 24}, '{16'h0002, 16'h000b, 8'hca, 216 + 48},
		'{16'h0002, 16'h000c, 8'h01, 216 + 72}, '{16'h0002, 16'h000a, 8'h80, 216 + 24},
		'{16'h0004, 16'h000b, 8'h5c, 216 + 24 + 5}};
	localparam int PIN_IRQ = 0;
	localparam int PIN_RTS = 1;
	localparam int PIN_TXD = 2;
	// About four percent slow and fast against 24 clocks a bit
	fsp_rx_row_t rx_rows[3] = '{'{8'h96, 24}, '{8'h3c, 25}, '{8'ha5, 23}};

	fsp_serial_port u_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .serial_receive_line(rxd), .serial_transmit_line(txd),
		.clear_to_send_input(cts), .request_to_send_output(rts), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .receive_ready_flag(ready), .irq(irq));
	fsp_remote u_partner (.clock(clock), .line_out(rxd), .line_in(txd), .cts(cts), .rts(rts));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (mem_write === 1'b1) begin
			mem_seen.push_back({mem_addr, mem_wdata});
		end
	end
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Leading edge wait keeps one strobe assignment per time step between calls
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Pins are picked by number so the wait needs no reference argument
	function automatic logic pin_level(input int sel);
		if (sel == PIN_IRQ) return irq;
		if (sel == PIN_RTS) return rts;
		return txd;
	endfunction
	task automatic wait_for(input int sel, input logic lvl, input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clock);
			#1;
			cnt++;
		end while (pin_level(sel) !== lvl && cnt < lim);
		if (pin_level(sel) !== lvl) begin
			check("wait bound", 24'h0, 24'h1);
			summarize();
		end
	endtask

	initial begin
		rstn = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		repeat (4) @(posedge clock);
		check("idle line", {txd, rts, ready, mem_write, irq}, 5'b10000);
		rstn <= 1'b1;
		foreach (reg_rows[i]) begin
			rd(reg_rows[i].addr, rd_val);
			check("register read", rd_val, reg_rows[i].value);
		end
		wr(`FSP_ADDR_MASK, 16'h0002);
		foreach (tx_rows[i]) begin
			wr(`FSP_ADDR_CTRL, tx_rows[i].ctrl);
			wr(`FSP_ADDR_GAP, tx_rows[i].gap);
			wr(`FSP_ADDR_TXDATA, {8'h00, tx_rows[i].data});
			wait_for(PIN_IRQ, 1'b1, 600, n);
			check("frame length", 24'(n), 24'(tx_rows[i].cycles));
			check("byte on line", u_partner.got, tx_rows[i].data);
			check("stop level", u_partner.stop_bit, 1'b1);
			wr(`FSP_ADDR_STATUS, 16'h0002);
			rd(`FSP_ADDR_STATUS, rd_val);
			check("done cleared", {rd_val, irq}, 17'h0);
		end
		wr(`FSP_ADDR_MASK, 16'h0000);
		wr(`FSP_ADDR_CTRL, 16'h0000);
		wr(`FSP_ADDR_TXDATA, 16'h0055);
		repeat (250) @(posedge clock);
		rd(`FSP_ADDR_STATUS, rd_val);
		check("masked done", {rd_val, irq}, {16'h0002, 1'b0});
		wr(`FSP_ADDR_MASK, 16'h0002);
		#1 check("unmasked done", irq, 1'b1);
		wr(`FSP_ADDR_STATUS, 16'h0002);
		u_partner.set_cts(1'b0);
		wr(`FSP_ADDR_CTRL, 16'h0004);
		wr(`FSP_ADDR_TXDATA, 16'h00c3);
		wait_for(PIN_RTS, 1'b1, 4, n);
		check("request raised", 24'(n), 24'd1);
		repeat (40) @(posedge clock);
		check("start held", txd, 1'b1);
		u_partner.set_cts(1'b1);
		wait_for(PIN_TXD, 1'b0, 8, n);
		check("start after clear", 24'(n), 24'd1);
		wait_for(PIN_RTS, 1'b0, 200, n);
		check("request drop", 24'(n), 24'd72);
		u_partner.set_cts(1'b0);
		wait_for(PIN_IRQ, 1'b1, 400, n);
		check("handshake byte", u_partner.got, 8'hc3);
		wr(`FSP_ADDR_STATUS, 16'h0002);
		wr(`FSP_ADDR_CTRL, 16'h0000);
		foreach (rx_rows[i]) begin
			u_partner.send_byte(rx_rows[i].data, rx_rows[i].len, 1'b1);
		end
		check("ready raised", ready, 1'b1);
		foreach (rx_rows[i]) begin
			rd(`FSP_ADDR_RXDATA, rd_val);
			check("received byte", rd_val, {8'h00, rx_rows[i].data});
		end
		rd(`FSP_ADDR_RXDATA, rd_val);
		check("empty read", {rd_val, ready}, 17'h0);
		wr(`FSP_ADDR_STATUS, 16'h000f);
		u_partner.send_byte(8'h77, 24, 1'b0);
		rd(`FSP_ADDR_STATUS, rd_val);
		check("framing error", {rd_val, ready}, {16'h0008, 1'b0});
		wr(`FSP_ADDR_STATUS, 16'h000f);
		for (int i = 0; i < 9; i++) begin
			u_partner.send_byte(8'(i), 24, 1'b1);
		end
		rd(`FSP_ADDR_STATUS, rd_val);
		check("overrun", rd_val, 16'h0105);
		for (int i = 0; i < 8; i++) begin
			rd(`FSP_ADDR_RXDATA, rd_val);
			check("full queue byte", rd_val, 16'(i));
		end
		check("queue drained", ready, 1'b0);
		wr(`FSP_ADDR_BLKADDR, 16'h0100);
		wr(`FSP_ADDR_CTRL, 16'h0001);
		u_partner.send_byte(8'h5a, 24, 1'b1);
		u_partner.send_byte(8'h0f, 24, 1'b1);
		check("block writes", 24'(mem_seen.size()), 24'd2);
		check("first block byte", mem_seen[0], 24'h01005a);
		check("second block byte", mem_seen[1], 24'h01010f);
		check("no queue in block", ready, 1'b0);
		wr(`FSP_ADDR_GAP, 16'h0020);
		@(posedge clock);
		rstn <= 1'b0;
		@(posedge clock);
		check("reset outputs", {txd, rts, ready, mem_write, irq, reg_rdata}, {5'b10000, 16'h0000});
		rstn <= 1'b1;
		rd(`FSP_ADDR_GAP, rd_val);
		check("gap after reset", rd_val, 16'h000b);
		rd(`FSP_ADDR_BLKADDR, rd_val);
		check("block address after reset", rd_val, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire

//--- verif/fsp_remote.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_remote (
	// Clock
	input wire logic clock,
	// Serial link
	output logic line_out,
	input wire logic line_in,
	output logic cts,
	input wire logic rts
);
	int bt = 24;
	logic [7:0] got;
	logic stop_bit;
	initial begin
		line_out = 1'b1;
		cts = 1'b1;
	end
	// Drop well ahead of the request, raise only when willing to hold until the start bit
	task automatic set_cts(input logic level);
		cts <= level;
	endtask
	// Caller enters just after a rising edge; len differs from bt to model rate error
	task automatic send_byte(input logic [7:0] data, input int len, input logic stop_level);
		line_out <= 1'b0;
		repeat (len) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			line_out <= data[i];
			repeat (len) @(posedge clock);
		end
		line_out <= stop_level;
		repeat (len) @(posedge clock);
		// A broken stop is followed by an idle bit so the line rests high again
		if (!stop_level) begin
			line_out <= 1'b1;
			repeat (len) @(posedge clock);
		end
	endtask
	// Samples mid-bit counted from the falling start edge
	always begin
		@(negedge line_in);
		repeat (bt / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge clock);
			got[i] = line_in;
		end
		repeat (bt) @(posedge clock);
		stop_bit = line_in;
	end
endmodule
`default_nettype wire
